// File: design/jt_tap.sv
// test access port: controller, instruction, bypass and identification registers
// assumes tck comes from the external test controller and may stop between scans
`timescale 1ns/1ps
`include "jt_defs.svh"
module jt_tap
  import jt_pkg::*;
#(
  parameter int           IR_W   = `JT_IR_W,
  // arbitrary identification value, bit 0 set as the standard asks
  parameter logic [31:0]  ID_VAL = 32'h0a5c_3001
) (
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic            tck,
  input  wire logic            tms_in,
  input  wire logic            tms_driven,
  input  wire logic            tdi_in,
  input  wire logic            tdi_driven,
  output logic                 tdo,
  output logic                 tdo_oe,
  output logic [IR_W-1:0]      active_instr,
  output logic                 instr_strobe,
  output logic                 tap_in_reset
);

  function automatic jt_state_t jt_step(input jt_state_t s, input logic m);
    case (s)
      JT_TLR:      jt_step = m ? JT_TLR : JT_IDLE;
      JT_IDLE:     jt_step = m ? JT_SEL_DR : JT_IDLE;
      JT_SEL_DR:   jt_step = m ? JT_SEL_IR : JT_CAP_DR;
      JT_CAP_DR:   jt_step = m ? JT_EXIT1_DR : JT_SHIFT_DR;
      JT_SHIFT_DR: jt_step = m ? JT_EXIT1_DR : JT_SHIFT_DR;
      JT_EXIT1_DR: jt_step = m ? JT_UPD_DR : JT_PAUSE_DR;
      JT_PAUSE_DR: jt_step = m ? JT_EXIT2_DR : JT_PAUSE_DR;
      JT_EXIT2_DR: jt_step = m ? JT_UPD_DR : JT_SHIFT_DR;
      JT_UPD_DR:   jt_step = m ? JT_SEL_DR : JT_IDLE;
      JT_SEL_IR:   jt_step = m ? JT_TLR : JT_CAP_IR;
      JT_CAP_IR:   jt_step = m ? JT_EXIT1_IR : JT_SHIFT_IR;
      JT_SHIFT_IR: jt_step = m ? JT_EXIT1_IR : JT_SHIFT_IR;
      JT_EXIT1_IR: jt_step = m ? JT_UPD_IR : JT_PAUSE_IR;
      JT_PAUSE_IR: jt_step = m ? JT_EXIT2_IR : JT_PAUSE_IR;
      JT_EXIT2_IR: jt_step = m ? JT_UPD_IR : JT_SHIFT_IR;
      JT_UPD_IR:   jt_step = m ? JT_SEL_DR : JT_IDLE;
      default:     jt_step = JT_TLR;
    endcase
  endfunction

  // pull-up on undriven inputs; the clock pad pull-up sits in the pad ring
  logic tms_eff;
  logic tdi_eff;
  assign tms_eff = tms_driven ? tms_in : 1'b1;
  assign tdi_eff = tdi_driven ? tdi_in : 1'b1;

  // system reset carried into the test clock domain
  logic rst_s1;
  logic rst_s2;
  always_ff @(posedge tck) begin
    rst_s1 <= reset;
    rst_s2 <= rst_s1;
  end
  logic trst;
  assign trst = rst_s2;

  jt_state_t        state;
  jt_state_t        next_state;
  logic [IR_W-1:0]  ir_shift;
  logic [IR_W-1:0]  next_ir_shift;
  logic [IR_W-1:0]  ir;
  logic [IR_W-1:0]  next_ir;
  logic [31:0]      id_shift;
  logic [31:0]      next_id_shift;
  logic             byp;
  logic             next_byp;
  logic             upd_tgl;
  logic             next_upd_tgl;
  logic             in_tlr;
  logic             next_in_tlr;

  logic sel_id;
  assign sel_id = (ir == IR_W'(`JT_IR_IDCODE));

  always_comb begin
    // controller steps on mode select only
    next_state    = jt_step(state, tms_eff);
    next_ir_shift = ir_shift;
    next_ir       = ir;
    next_id_shift = id_shift;
    next_byp      = byp;
    next_upd_tgl  = upd_tgl;
    // serial data taken into the selected register
    case (state)
      JT_TLR:      next_ir = IR_W'(`JT_IR_IDCODE);
      JT_CAP_IR:   next_ir_shift = {{(IR_W-2){1'b0}}, `JT_IR_CAPTURE};
      JT_SHIFT_IR: next_ir_shift = {tdi_eff, ir_shift[IR_W-1:1]};
      JT_UPD_IR: begin
        next_ir      = ir_shift;
        next_upd_tgl = ~upd_tgl;
      end
      JT_CAP_DR: begin
        next_id_shift = ID_VAL;
        next_byp      = 1'b0;
      end
      JT_SHIFT_DR: begin
        if (sel_id) begin
          next_id_shift = {tdi_eff, id_shift[31:1]};
        end else begin
          next_byp = tdi_eff;
        end
      end
      default: next_upd_tgl = upd_tgl;
    endcase
    // registered so the system side never decodes a moving state word
    next_in_tlr = (next_state == JT_TLR);
  end

  // every test register runs on the test clock
  always_ff @(posedge tck) begin
    if (trst) begin
      state    <= JT_TLR;
      ir_shift <= '0;
      ir       <= IR_W'(`JT_IR_IDCODE);
      id_shift <= '0;
      byp      <= 1'b0;
      upd_tgl  <= 1'b0;
      in_tlr   <= 1'b1;
    end else begin
      state    <= next_state;
      ir_shift <= next_ir_shift;
      ir       <= next_ir;
      id_shift <= next_id_shift;
      byp      <= next_byp;
      upd_tgl  <= next_upd_tgl;
      in_tlr   <= next_in_tlr;
    end
  end

  // output stage on the falling edge, half a cycle of margin for the sampler
  logic in_shift;
  logic next_tdo_q;
  logic next_oe_q;
  logic tdo_q;
  logic oe_q;
  assign in_shift = (state == JT_SHIFT_DR) || (state == JT_SHIFT_IR);
  always_comb begin
    next_oe_q  = in_shift;
    next_tdo_q = tdo_q;
    if (state == JT_SHIFT_IR) begin
      next_tdo_q = ir_shift[0];
    end else if (state == JT_SHIFT_DR) begin
      next_tdo_q = sel_id ? id_shift[0] : byp;
    end
  end
  always_ff @(negedge tck) begin
    if (trst) begin
      tdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      tdo_q <= next_tdo_q;
      oe_q  <= next_oe_q;
    end
  end
  // released outside shift states and while the carried reset trst is held
  assign tdo    = tdo_q;
  assign tdo_oe = oe_q & ~trst;

  // system side: instruction handed over by toggle; ir is stable long after the toggle
  logic [2:0]       tgl_s;
  logic [1:0]       tlr_s;
  logic [2:0]       next_tgl_s;
  logic [1:0]       next_tlr_s;
  logic [IR_W-1:0]  next_active;
  logic             next_strobe;
  always_comb begin
    next_tgl_s  = {tgl_s[1:0], upd_tgl};
    next_tlr_s  = {tlr_s[0], in_tlr};
    next_strobe = tgl_s[2] ^ tgl_s[1];
    next_active = next_strobe ? ir : active_instr;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      tgl_s        <= '0;
      tlr_s        <= '0;
      active_instr <= IR_W'(`JT_IR_IDCODE);
      instr_strobe <= 1'b0;
    end else begin
      tgl_s        <= next_tgl_s;
      tlr_s        <= next_tlr_s;
      active_instr <= next_active;
      instr_strobe <= next_strobe;
    end
  end
  assign tap_in_reset = tlr_s[1];

  // system reset also masks the first tck edges, before the carried reset has settled, for all checks but reset_tlr_a and pull_up_a
  tlr_five_ones_a: assert property (@(posedge tck) disable iff (reset || trst)
    tms_eff [*5] |=> state == JT_TLR) else $error("five ones did not reach reset");
  cap_to_shift_a: assert property (@(posedge tck) disable iff (reset || trst)
    (state == JT_CAP_DR && !tms_eff) |=> state == JT_SHIFT_DR)
    else $error("capture did not move to shift");
  reset_tlr_a: assert property (@(posedge tck)
    trst |=> state == JT_TLR) else $error("reset did not reach test logic reset");
  oe_shift_a: assert property (@(posedge tck) disable iff (reset || trst)
    tdo_oe == in_shift) else $error("output enable outside shift states");
  byp_out_a: assert property (@(posedge tck) disable iff (reset || trst)
    (state == JT_SHIFT_DR && !sel_id && $past(state) == JT_SHIFT_DR) |-> tdo == byp)
    else $error("bypass bit not on output");
  byp_take_a: assert property (@(posedge tck) disable iff (reset || trst)
    (state == JT_SHIFT_DR && !sel_id) |=> byp == $past(tdi_eff))
    else $error("bypass did not take input");
  ir_capture_a: assert property (@(posedge tck) disable iff (reset || trst)
    state == JT_CAP_IR |=> ir_shift[1:0] == `JT_IR_CAPTURE)
    else $error("instruction capture pattern wrong");
  tlr_idcode_a: assert property (@(posedge tck) disable iff (reset || trst)
    $past(state) == JT_TLR |-> ir == IR_W'(`JT_IR_IDCODE))
    else $error("identification not selected after reset");
  pull_up_a: assert property (@(posedge tck)
    (!tdi_driven |-> tdi_eff) and (!tms_driven |-> tms_eff))
    else $error("undriven input not high");

endmodule

// File: dv/jt_ctl.sv
// model of the far test controller: drives tck only inside scans, tms and tdi
// assumes the port samples at rising tck and moves tdo at falling tck
`timescale 1ns/1ps
module jt_ctl (
  output logic      tck,
  output logic      tms_in,
  output logic      tdi_in,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic last = 1'b0;
  // a released line shows the inverse of the last driven bit
  wire  line = tdo_oe ? tdo : ~last;
  always @(tdo) if (tdo_oe) last = tdo;
  initial begin
    tck = 1'b0;
    tms_in = 1'b1;
    tdi_in = 1'b1;
  end
  // one tms value per cycle, stable around rise
  task automatic step(input logic m, input logic d, output logic q, output logic oe);
    tms_in = m;
    tdi_in = d;
    #7.5;
    q = line;
    oe = tdo_oe;
    tck = 1'b1;
    #7.5;
    tck = 1'b0;
  endtask
  task automatic go(input logic [7:0] seq, input int n);
    logic q, oe;
    for (int i = 0; i < n; i++) step(seq[i], 1'b1, q, oe);
  endtask
  // lsb first; last bit leaves shift, then update and back to idle
  task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout,
                       output logic oe_all);
    logic q, oe;
    dout = '0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q, oe);
      dout[i] = q;
      oe_all &= oe;
    end
    go(8'h01, 2);
  endtask
endmodule

// File: dv/jtag_test_access_port_bench.sv
// bench of the test access port: reset, instruction and data scans, pull-ups
// assumes jt_ctl as the far controller; tck runs at 15 ns only inside scans
`timescale 1ns/1ps
module jtag_test_access_port_bench;
  // arbitrary identification value
  localparam logic [31:0] ID = 32'h0a5c_3001;
  logic        clock, tck, tms_in, tdi_in, tdo, tdo_oe, instr_strobe, tap_in_reset, oe;
  logic        reset = 1'b1, tms_driven = 1'b1, tdi_driven = 1'b1;
  logic [3:0]  active_instr;
  logic [31:0] d;
  int          n_mismatch = 0, checks = 0;
  jt_tap #(.ID_VAL(ID)) uut (.clock(clock), .reset(reset), .tck(tck), .tms_in(tms_in),
    .tms_driven(tms_driven), .tdi_in(tdi_in), .tdi_driven(tdi_driven), .tdo(tdo),
    .tdo_oe(tdo_oe), .active_instr(active_instr), .instr_strobe(instr_strobe),
    .tap_in_reset(tap_in_reset));
  jt_ctl partner (.tck(tck), .tms_in(tms_in), .tdi_in(tdi_in), .tdo(tdo), .tdo_oe(tdo_oe));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(tdo) check(tck, 1'b0);
  always @(tdo_oe) check(tck, 1'b0);
  task automatic t_reset();
    fork
      repeat (6) @(posedge clock);
      partner.go(8'hff, 8);
    join
    check(tdo_oe, 1'b0);
    reset <= 1'b0;
    partner.go(8'h1f, 5);
    repeat (4) @(negedge clock);
    check(tap_in_reset, 1'b1);
    check(active_instr, 4'h1);
    partner.go(8'h00, 1);
  endtask
  task automatic t_dr(input logic [31:0] din, input int n, input logic [31:0] exp);
    partner.go(8'h01, 3);
    partner.shift(din, n, d, oe);
    check(d, exp);
    check(oe, 1'b1);
    check(tdo_oe, 1'b0);
  endtask
  task automatic t_ir(input logic [3:0] code, input logic [3:0] exp);
    partner.go(8'h03, 4);
    partner.shift(code, 4, d, oe);
    check(d[1:0], 2'h1);
    check(oe, 1'b1);
    for (int i = 0; i < 10 && instr_strobe !== 1'b1; i++) @(negedge clock);
    check(instr_strobe, 1'b1);
    check(active_instr, exp);
    check(tap_in_reset, 1'b0);
  endtask
  task automatic t_tdi_pull();
    @(posedge clock) tdi_driven <= 1'b0;
    t_ir(4'h0, 4'hf);
    t_dr(32'h0, 8, 32'hfe);
  endtask
  task automatic t_tms_pull();
    @(posedge clock) tms_driven <= 1'b0;
    partner.go(8'h00, 5);
    repeat (4) @(negedge clock);
    check(tap_in_reset, 1'b1);
  endtask
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
  initial begin
    t_reset();
    t_dr(32'h0, 32, ID);
    t_ir(4'hf, 4'hf);
    t_dr(32'ha5, 8, 32'h4a);
    t_ir(4'h5, 4'h5);
    t_dr(32'ha5, 8, 32'h4a);
    t_ir(4'h1, 4'h1);
    t_dr(32'h0, 32, ID);
    t_tdi_pull();
    t_tms_pull();
    close_out();
  end
endmodule

// File: shared/jt_defs.svh
// constants of the test access port: instruction codes, capture patterns, widths
// assumes nothing of its surroundings; included by bare name
`ifndef JT_DEFS_SVH
`define JT_DEFS_SVH
`define JT_IR_W          4
`define JT_IR_BYPASS     4'hf
`define JT_IR_IDCODE     4'h1
`define JT_IR_CAPTURE    2'h1
`define JT_ID_W          32
`define JT_SYNC_STAGES   2
`endif

// File: shared/jt_pkg.sv
// types of the test access port
// assumes the includer has no other package with the same names
package jt_pkg;
  // gray steps along the data-register column
  typedef enum logic [3:0] {
    JT_TLR      = 4'h0,
    JT_IDLE     = 4'h1,
    JT_SEL_DR   = 4'h3,
    JT_CAP_DR   = 4'h2,
    JT_SHIFT_DR = 4'h6,
    JT_EXIT1_DR = 4'h7,
    JT_PAUSE_DR = 4'h5,
    JT_EXIT2_DR = 4'h4,
    JT_UPD_DR   = 4'hc,
    JT_SEL_IR   = 4'hd,
    JT_CAP_IR   = 4'hf,
    JT_SHIFT_IR = 4'he,
    JT_EXIT1_IR = 4'ha,
    JT_PAUSE_IR = 4'hb,
    JT_EXIT2_IR = 4'h9,
    JT_UPD_IR   = 4'h8
  } jt_state_t;
endpackage
